// file: rtl/hpfc_cfg.svh
// Constants for the host port flow-control register block.
// Assumes a 250 MHz system clock and a 32-bit APB register bus.
`ifndef HPFC_CFG_SVH
`define HPFC_CFG_SVH

// Bus geometry
`define HPFC_ADDR_W 12
`define HPFC_DATA_W 32
`define HPFC_REG_OFFSET 12'h01a8

// Field positions
`define HPFC_BIT_HW_FC 7
`define HPFC_BIT_BP_EN 6
`define HPFC_BIT_CUR_DUP 5
`define HPFC_BIT_CUR_RX 4
`define HPFC_BIT_CUR_TX 3
`define HPFC_BIT_RX_EN 2
`define HPFC_BIT_TX_EN 1
`define HPFC_BIT_MANUAL 0
`define HPFC_FIELD_W 8

// Reset value of the hard-wired bit
`define HPFC_HW_FC_RST 1'h0

// FIFO level width and strap count
`define HPFC_LEVEL_W 8
`define HPFC_STRAP_N 4

// Cycles from reset release until the straps are taken
`define HPFC_STRAP_SETTLE 3'h5

`endif

// file: rtl/hpfc_pkg.sv
// Types for the host port flow-control register block.
// Assumes hpfc_cfg.svh is compiled alongside.
`include "hpfc_cfg.svh"

package hpfc_pkg;
    // Start-up sequence of the strap capture
    typedef enum logic [0:0] {
        HPFC_SETTLE,
        HPFC_RUN
    } hpfc_boot_t;

    // One FIFO fill level
    typedef logic [`HPFC_LEVEL_W-1:0] hpfc_level_t;
endpackage : hpfc_pkg

// file: rtl/hpfc_sync.sv
// Three-stage synchroniser for slow strap pins, one per bit.
// Assumes levels that stay put for several clocks.
`timescale 1ns/1ps

module hpfc_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Pins and result
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // One chain per bit; the first stage feeds only the second
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic s1;
        logic s2;
        logic s3;
        always_ff @(posedge mclk_in) begin
            if (sys_rst_in) begin
                s1 <= 1'h0;
                s2 <= 1'h0;
                s3 <= 1'h0;
                sync_out[i] <= 1'h0;
            end else begin
                s1 <= async_in[i];
                s2 <= s1;
                s3 <= s2;
                // Accept a change only once two late stages agree
                if (s2 == s3) begin
                    sync_out[i] <= s3;
                end
            end
        end
    end
endmodule : hpfc_sync

// file: rtl/hpfc_top.sv
// Port 0 flow-control configuration and status register over APB.
// Assumes negotiation results and FIFO levels arrive on mclk_in;
// strap pins are asynchronous and settle before reset ends.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "hpfc_cfg.svh"

module hpfc_top (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [`HPFC_ADDR_W-1:0] paddr_in,
    input wire logic [`HPFC_DATA_W-1:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [`HPFC_DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Strap pins, asynchronous
    input wire logic backpressure_strap_in,
    input wire logic full_duplex_pause_strap_in,
    input wire logic manual_select_strap_in,
    input wire logic half_duplex_strap_in,
    // EEPROM loader rewrite of the straps
    input wire logic eeprom_strap_load_in,
    input wire logic eeprom_backpressure_in,
    input wire logic eeprom_full_duplex_pause_in,
    input wire logic eeprom_manual_select_in,
    input wire logic eeprom_half_duplex_in,
    // Virtual negotiation outcome
    input wire logic vneg_enable_in,
    input wire logic vneg_half_duplex_in,
    input wire logic vneg_rx_pause_in,
    input wire logic vneg_tx_pause_in,
    // FIFO levels
    input wire hpfc_pkg::hpfc_level_t host_rx_level_in,
    input wire hpfc_pkg::hpfc_level_t engine_rx_level_in,
    // Port 0 controls
    output hpfc_pkg::hpfc_level_t engine_tx_fc_level_out,
    output hpfc_pkg::hpfc_level_t host_tx_fc_level_out,
    output logic hardwired_fc_active_out,
    output logic pause_detect_en_out,
    output logic pause_gen_en_out,
    output logic backpressure_gen_out
);
    // Writable fields
    logic hardwired_fifo_flow_control;
    logic backpressure_enable;
    logic rx_pause_enable;
    logic tx_pause_enable;
    logic manual_pause_select;
    // Strap-derived duplex default
    logic duplex_cfg;
    // Resolved status
    logic current_duplex;
    logic current_rx_pause_enable;
    logic current_tx_pause_enable;
    logic next_half;
    logic next_rx;
    logic next_tx;
    // Start-up
    hpfc_pkg::hpfc_boot_t boot_state;
    logic [2:0] boot_cnt;
    logic boot_load;
    logic [`HPFC_STRAP_N-1:0] strap_sync;
    // Bus decode
    logic access;
    logic hit;
    logic wr_commit;
    logic [`HPFC_DATA_W-1:0] rd_word;

    // Strap pins cross into the clock domain
    hpfc_sync #(
        .W(`HPFC_STRAP_N)
    ) u_strap_sync (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({half_duplex_strap_in, manual_select_strap_in,
                   full_duplex_pause_strap_in, backpressure_strap_in}),
        .sync_out(strap_sync)
    );

    // Straps taken once the synchroniser has settled after reset
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            boot_state <= hpfc_pkg::HPFC_SETTLE;
            boot_cnt <= 3'h0;
        end else begin
            case (boot_state)
                hpfc_pkg::HPFC_SETTLE: begin
                    boot_cnt <= boot_cnt + 3'h1;
                    if (boot_cnt == `HPFC_STRAP_SETTLE) begin
                        boot_state <= hpfc_pkg::HPFC_RUN;
                    end
                end
                hpfc_pkg::HPFC_RUN: begin
                    boot_cnt <= boot_cnt;
                end
                default: begin
                    boot_state <= hpfc_pkg::HPFC_SETTLE;
                    boot_cnt <= 3'h0;
                end
            endcase
        end
    end

    assign boot_load = (boot_state == hpfc_pkg::HPFC_SETTLE) &&
                       (boot_cnt == `HPFC_STRAP_SETTLE);

    // APB decode; one wait state keeps every answer on a flop
    assign access = psel_in & penable_in;
    assign hit = (paddr_in == `HPFC_REG_OFFSET);
    assign wr_commit = access & pready_out & pwrite_in & hit;

    // Reserved bits stay zero on reads
    always_comb begin
        rd_word = '0;
        rd_word[`HPFC_BIT_HW_FC] = hardwired_fifo_flow_control;
        rd_word[`HPFC_BIT_BP_EN] = backpressure_enable;
        rd_word[`HPFC_BIT_CUR_DUP] = current_duplex;
        rd_word[`HPFC_BIT_CUR_RX] = current_rx_pause_enable;
        rd_word[`HPFC_BIT_CUR_TX] = current_tx_pause_enable;
        rd_word[`HPFC_BIT_RX_EN] = rx_pause_enable;
        rd_word[`HPFC_BIT_TX_EN] = tx_pause_enable;
        rd_word[`HPFC_BIT_MANUAL] = manual_pause_select;
    end

    // Handshake: ready rises one cycle into the access phase
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            pready_out <= 1'h0;
            pslverr_out <= 1'h0;
            prdata_out <= '0;
        end else if (access && !pready_out) begin
            pready_out <= 1'h1;
            pslverr_out <= !hit; // Unmapped address answers with an error
            prdata_out <= (hit && !pwrite_in) ? rd_word : '0;
        end else begin
            pready_out <= 1'h0;
            pslverr_out <= 1'h0;
            prdata_out <= '0;
        end
    end

    // Writable fields; the loader beats a write in the same cycle
    // Only this word's own bits change, nothing in the advertisement
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            hardwired_fifo_flow_control <= `HPFC_HW_FC_RST;
            backpressure_enable <= 1'h0;
            rx_pause_enable <= 1'h0;
            tx_pause_enable <= 1'h0;
            manual_pause_select <= 1'h0;
            duplex_cfg <= 1'h0;
        end else if (boot_load) begin
            backpressure_enable <= strap_sync[0];
            rx_pause_enable <= strap_sync[1];
            tx_pause_enable <= strap_sync[1];
            manual_pause_select <= strap_sync[2];
            duplex_cfg <= strap_sync[3];
        end else if (eeprom_strap_load_in) begin
            backpressure_enable <= eeprom_backpressure_in;
            rx_pause_enable <= eeprom_full_duplex_pause_in;
            tx_pause_enable <= eeprom_full_duplex_pause_in;
            manual_pause_select <= eeprom_manual_select_in;
            duplex_cfg <= eeprom_half_duplex_in;
        end else if (wr_commit && pstrb_in[0]) begin
            hardwired_fifo_flow_control <= pwdata_in[`HPFC_BIT_HW_FC];
            backpressure_enable <= pwdata_in[`HPFC_BIT_BP_EN];
            rx_pause_enable <= pwdata_in[`HPFC_BIT_RX_EN];
            tx_pause_enable <= pwdata_in[`HPFC_BIT_TX_EN];
            manual_pause_select <= pwdata_in[`HPFC_BIT_MANUAL];
        end
    end

    // Resolution of duplex and pause enables
    always_comb begin
        next_half = vneg_enable_in ? vneg_half_duplex_in : duplex_cfg;
        if (next_half) begin
            next_rx = 1'h0;
            next_tx = 1'h0;
        end else if (manual_pause_select || !vneg_enable_in) begin
            next_rx = rx_pause_enable;
            next_tx = tx_pause_enable;
        end else begin
            next_rx = vneg_rx_pause_in;
            next_tx = vneg_tx_pause_in;
        end
    end

    // Status and port controls; held off until straps are in
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || boot_state != hpfc_pkg::HPFC_RUN) begin
            current_duplex <= 1'h0;
            current_rx_pause_enable <= 1'h0;
            current_tx_pause_enable <= 1'h0;
            backpressure_gen_out <= 1'h0;
        end else begin
            current_duplex <= next_half;
            current_rx_pause_enable <= next_rx;
            current_tx_pause_enable <= next_tx;
            backpressure_gen_out <= backpressure_enable & next_half;
        end
    end

    assign pause_detect_en_out = current_rx_pause_enable;
    assign pause_gen_en_out = current_tx_pause_enable;

    // Level cross-connect; software must have shut other methods off
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            engine_tx_fc_level_out <= '0;
            host_tx_fc_level_out <= '0;
            hardwired_fc_active_out <= 1'h0;
        end else begin
            hardwired_fc_active_out <= hardwired_fifo_flow_control;
            engine_tx_fc_level_out <= hardwired_fifo_flow_control ?
                                      host_rx_level_in : '0;
            host_tx_fc_level_out <= hardwired_fifo_flow_control ?
                                    engine_rx_level_in : '0;
        end
    end

    // Checks on the resolved behaviour
    logic run;
    assign run = (boot_state == hpfc_pkg::HPFC_RUN);

    property p_hw_levels;
        @(posedge mclk_in) disable iff (sys_rst_in)
        hardwired_fifo_flow_control |=>
            engine_tx_fc_level_out == $past(host_rx_level_in) &&
            host_tx_fc_level_out == $past(engine_rx_level_in);
    endproperty
    a_hw_levels: assert property (p_hw_levels)
        else $error("level cross-connect wrong");

    property p_hw_off;
        @(posedge mclk_in) disable iff (sys_rst_in)
        !hardwired_fifo_flow_control |=>
            engine_tx_fc_level_out == '0 && host_tx_fc_level_out == '0;
    endproperty
    a_hw_off: assert property (p_hw_off)
        else $error("levels passed while hard-wired off");

    property p_bp;
        @(posedge mclk_in) disable iff (sys_rst_in)
        run && backpressure_enable && next_half |=> backpressure_gen_out;
    endproperty
    a_bp: assert property (p_bp)
        else $error("backpressure not generated");

    property p_dup;
        @(posedge mclk_in) disable iff (sys_rst_in)
        run && vneg_enable_in |=> current_duplex == $past(vneg_half_duplex_in);
    endproperty
    a_dup: assert property (p_dup)
        else $error("current duplex wrong");

    property p_half;
        @(posedge mclk_in) disable iff (sys_rst_in)
        current_duplex |-> !pause_detect_en_out && !pause_gen_en_out;
    endproperty
    a_half: assert property (p_half)
        else $error("pause enabled in half duplex");

    property p_man_rx;
        @(posedge mclk_in) disable iff (sys_rst_in)
        run && (manual_pause_select || !vneg_enable_in) && !next_half
            |=> current_rx_pause_enable == $past(rx_pause_enable);
    endproperty
    a_man_rx: assert property (p_man_rx)
        else $error("manual rx pause not applied");

    property p_man_tx;
        @(posedge mclk_in) disable iff (sys_rst_in)
        run && (manual_pause_select || !vneg_enable_in) && !next_half
            |=> current_tx_pause_enable == $past(tx_pause_enable);
    endproperty
    a_man_tx: assert property (p_man_tx)
        else $error("manual tx pause not applied");

    property p_neg;
        @(posedge mclk_in) disable iff (sys_rst_in)
        run && !manual_pause_select && vneg_enable_in && !vneg_half_duplex_in
            |=> current_tx_pause_enable == $past(vneg_tx_pause_in) &&
                current_rx_pause_enable == $past(vneg_rx_pause_in);
    endproperty
    a_neg: assert property (p_neg)
        else $error("negotiated pause not applied");

    property p_eeprom;
        @(posedge mclk_in) disable iff (sys_rst_in)
        !boot_load && eeprom_strap_load_in |=>
            backpressure_enable == $past(eeprom_backpressure_in) &&
            manual_pause_select == $past(eeprom_manual_select_in);
    endproperty
    a_eeprom: assert property (p_eeprom)
        else $error("loader value not taken");

    property p_rsvd;
        @(posedge mclk_in) disable iff (sys_rst_in)
        pready_out |-> prdata_out[`HPFC_DATA_W-1:`HPFC_FIELD_W] == '0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits not zero");

    property p_ready;
        @(posedge mclk_in) disable iff (sys_rst_in)
        psel_in && !penable_in ##1 psel_in && penable_in |=> pready_out;
    endproperty
    a_ready: assert property (p_ready)
        else $error("no answer one cycle into access");

    // Straps land in the fields at the capture edge
    property p_strap;
        @(posedge mclk_in) disable iff (sys_rst_in)
        boot_load |=>
            backpressure_enable == $past(strap_sync[0]) &&
            rx_pause_enable == $past(strap_sync[1]) &&
            manual_pause_select == $past(strap_sync[2]);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap value not captured");

    // A committed write with lane 0 lands unless a hardware load wins
    property p_wr;
        @(posedge mclk_in) disable iff (sys_rst_in)
        wr_commit && pstrb_in[0] && !boot_load && !eeprom_strap_load_in |=>
            hardwired_fifo_flow_control == $past(pwdata_in[`HPFC_BIT_HW_FC]) &&
            tx_pause_enable == $past(pwdata_in[`HPFC_BIT_TX_EN]);
    endproperty
    a_wr: assert property (p_wr)
        else $error("write did not land");

    // Unmapped addresses answer with an error, mapped ones without
    property p_err;
        @(posedge mclk_in) disable iff (sys_rst_in)
        access && !pready_out |=> pready_out && pslverr_out == !$past(hit);
    endproperty
    a_err: assert property (p_err)
        else $error("error response wrong");

    // No backpressure while the port runs full duplex
    property p_bp_off;
        @(posedge mclk_in) disable iff (sys_rst_in)
        run && !next_half |=> !backpressure_gen_out;
    endproperty
    a_bp_off: assert property (p_bp_off)
        else $error("backpressure outside half duplex");

    // Main scenarios
    c_hw: cover property (@(posedge mclk_in) hardwired_fc_active_out);
    c_half: cover property (@(posedge mclk_in) backpressure_gen_out);
    c_load: cover property (@(posedge mclk_in) run && eeprom_strap_load_in);
    c_err: cover property (@(posedge mclk_in) pready_out && pslverr_out);
    c_neg: cover property (@(posedge mclk_in) run && vneg_enable_in && !manual_pause_select);
endmodule : hpfc_top

// file: test/hpfc_fifo_model.sv
// Far-side model: host MAC and switch engine receive FIFO fill levels.
// Assumes one clock shared with the block under test.
`timescale 1ns/1ps

module hpfc_fifo_model (
    // Clock
    input wire logic mclk_in,
    // FIFO levels towards the block
    output hpfc_pkg::hpfc_level_t host_rx_level_out,
    output hpfc_pkg::hpfc_level_t engine_rx_level_out
);
    // Fresh levels every cycle, so a stale or swapped path shows at once
    always @(posedge mclk_in) begin
        host_rx_level_out <= 8'($urandom);
        engine_rx_level_out <= 8'($urandom);
    end
endmodule : hpfc_fifo_model

// file: test/testbench.sv
// Self-checking bench for the port 0 flow-control register over APB.
// Assumes the FIFO model drives levels; bench drives straps, loader, negotiation.
`timescale 1ns/1ps
`include "hpfc_cfg.svh"

module testbench;
    // Clock, reset, APB
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    // Straps {half, manual, fd pause, bp}, loader, negotiation {tx, rx, half, en}
    logic [3:0] strap = 4'h0;
    logic ld = 1'b0;
    logic [3:0] ee = 4'h0;
    logic [3:0] vn = 4'h0;
    hpfc_pkg::hpfc_level_t host_lvl, eng_lvl, eng_tx, host_tx;
    logic hw_act, pdet, pgen, bpgen;
    int failures = 0;
    int tests_run = 0;
    // Bench copy of writable fields and duplex default
    logic [7:0] fld = 8'h00;
    logic hs = 1'b0;
    logic [31:0] rd;
    logic er;

    always #2 mclk_in = ~mclk_in;

    hpfc_fifo_model u_hpfc_fifo_model (.mclk_in(mclk_in), .host_rx_level_out(host_lvl),
        .engine_rx_level_out(eng_lvl));

    hpfc_top u_hpfc_top (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .backpressure_strap_in(strap[0]), .full_duplex_pause_strap_in(strap[1]),
        .manual_select_strap_in(strap[2]), .half_duplex_strap_in(strap[3]),
        .eeprom_strap_load_in(ld), .eeprom_backpressure_in(ee[0]),
        .eeprom_full_duplex_pause_in(ee[1]), .eeprom_manual_select_in(ee[2]),
        .eeprom_half_duplex_in(ee[3]), .vneg_enable_in(vn[0]), .vneg_half_duplex_in(vn[1]),
        .vneg_rx_pause_in(vn[2]), .vneg_tx_pause_in(vn[3]), .host_rx_level_in(host_lvl),
        .engine_rx_level_in(eng_lvl), .engine_tx_fc_level_out(eng_tx),
        .host_tx_fc_level_out(host_tx), .hardwired_fc_active_out(hw_act),
        .pause_detect_en_out(pdet), .pause_gen_en_out(pgen), .backpressure_gen_out(bpgen));

    task automatic end_of_test;
        if (failures == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; psel stays up so a next setup may follow at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk_in);
        pen <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge mclk_in);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        pen <= 1'b0;
    endtask : apb

    task automatic idle(input int c);
        psel <= 1'b0;
        repeat (c) @(posedge mclk_in);
    endtask : idle

    // Expected low byte from fields, negotiation and duplex default
    function automatic logic [7:0] exp_reg(input logic [7:0] f, input logic [3:0] v,
        input logic d);
        logic half;
        logic sel;
        half = v[0] ? v[1] : d;
        sel = f[0] | ~v[0];
        return {f[7:6], half, ~half & (sel ? f[2] : v[2]), ~half & (sel ? f[1] : v[3]), f[2:0]};
    endfunction : exp_reg

    // Read back, then check the port 0 controls and the FIFO cross path
    task automatic check_all;
        logic [7:0] e;
        logic [15:0] lv;
        e = exp_reg(fld, vn, hs);
        apb(1'b0, `HPFC_REG_OFFSET, 32'h0000_0000, 4'h0);
        idle(1);
        chk(rd, {24'h00_0000, e});
        chk({31'h0, er}, 32'h0000_0000);
        chk({28'h000_0000, hw_act, pdet, pgen, bpgen},
            {28'h000_0000, e[7], e[4], e[3], e[6] & e[5]});
        lv = {host_lvl, eng_lvl};
        @(posedge mclk_in);
        chk({16'h0000, eng_tx, host_tx}, {16'h0000, e[7] ? lv : 16'h0000});
    endtask : check_all

    task automatic do_reset;
        strap <= 4'($urandom);
        vn <= 4'($urandom);
        sys_rst_in <= 1'b1;
        repeat (20) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        repeat (10) @(posedge mclk_in);
        fld = {1'b0, strap[0], 3'b000, strap[1], strap[1], strap[2]};
        hs = strap[3];
        check_all();
    endtask : do_reset

    // Watchdog, far beyond the expected run of under a thousand cycles
    initial begin
        #80000;
        failures++;
        end_of_test();
    end

    initial begin
        logic [31:0] d;
        logic [11:0] a;
        logic [3:0] s;
        void'($urandom(32'h3e4a));
        do_reset();
        for (int i = 0; i < 40; i++) begin
            // Loader rewrite now and then, hardware values replace all fields but the hard-wired bit
            if (i % 7 == 5) begin
                ee <= 4'($urandom);
                ld <= 1'b1;
                @(posedge mclk_in);
                ld <= 1'b0;
                fld = {fld[7], ee[0], 3'b000, ee[1], ee[1], ee[2]};
                hs = ee[3];
            end
            d = $urandom;
            if (d[7]) d[6:0] = 7'h01;
            s = (i % 5 == 2) ? 4'he : 4'($urandom) | 4'h1;
            a = (i % 6 == 3) ? 12'(i * 4) : `HPFC_REG_OFFSET;
            vn <= 4'($urandom);
            apb(1'b1, a, d, s);
            chk({31'h0, er}, {31'h0, a != `HPFC_REG_OFFSET});
            if (s[0] && a == `HPFC_REG_OFFSET) fld = {d[7:6], 3'b000, d[2:0]};
            // Read straight after the write, no idle cycle between
            apb(1'b0, `HPFC_REG_OFFSET, 32'h0000_0000, 4'h0);
            chk(rd, {24'h00_0000, exp_reg(fld, vn, hs)});
            idle(2);
            check_all();
        end
        do_reset();
        end_of_test();
    end
endmodule : testbench
